// >>> ltm_pkg.sv
package ltm_pkg;

    // parameter addresses on the drive parameter port
    localparam logic [15:0] LTM_ADDR_SOFT_ENABLE = 16'h0606;
    localparam logic [15:0] LTM_ADDR_SOFT_POS = 16'h0608;
    localparam logic [15:0] LTM_ADDR_SOFT_NEG = 16'h060a;
    localparam logic [15:0] LTM_ADDR_REF_TYPE = 16'h061c;
    localparam logic [15:0] LTM_ADDR_NEG_TYPE = 16'h061e;
    localparam logic [15:0] LTM_ADDR_POS_TYPE = 16'h0620;
    localparam logic [15:0] LTM_ADDR_REACH = 16'h068e;

    // switch evaluation codes
    localparam logic [15:0] LTM_SW_IGNORED = 16'h0000;
    localparam logic [15:0] LTM_SW_NC = 16'h0001;
    localparam logic [15:0] LTM_SW_NO = 16'h0002;

    // soft limit enable codes, bit 0 positive, bit 1 negative
    localparam logic [15:0] LTM_SOFT_NONE = 16'h0000;
    localparam logic [15:0] LTM_SOFT_BOTH = 16'h0003;
    localparam int LTM_SOFT_POS_BIT = 0;
    localparam int LTM_SOFT_NEG_BIT = 1;

    // limit reach behaviour codes
    localparam logic [15:0] LTM_REACH_BEHIND = 16'h0000;
    localparam logic [15:0] LTM_REACH_AT = 16'h0001;

    // reset values
    localparam logic [15:0] LTM_RST_SWITCH_TYPE = 16'h0001;
    localparam logic [15:0] LTM_RST_REACH = 16'h0000;
    localparam logic [15:0] LTM_RST_SOFT_ENABLE = 16'h0000;
    localparam logic [31:0] LTM_RST_SOFT_POS = 32'h7fff_ffff;
    localparam logic [31:0] LTM_RST_SOFT_NEG = 32'h8000_0000;

    // error source bit positions
    localparam int LTM_ERR_HW_POS = 0;
    localparam int LTM_ERR_HW_NEG = 1;
    localparam int LTM_ERR_SW_POS = 2;
    localparam int LTM_ERR_SW_NEG = 3;
    localparam int LTM_ERR_W = 4;

    // drive operating states seen by this block
    typedef enum logic [3:0] {
        LTM_ST_DISABLED = 4'b0000,
        LTM_ST_OP_ENABLED = 4'b0110,
        LTM_ST_QUICK_STOP = 4'b0111
    } ltm_state_t;

    // operating modes
    typedef enum logic [2:0] {
        LTM_MODE_JOG_STEP = 3'b000,
        LTM_MODE_JOG_CONT = 3'b001,
        LTM_MODE_PROFILE_POS = 3'b010,
        LTM_MODE_PROFILE_VEL = 3'b011,
        LTM_MODE_PROFILE_TRQ = 3'b100,
        LTM_MODE_HOMING = 3'b101
    } ltm_mode_t;

endpackage

// >>> ltm_switch_model.sv
`timescale 1ns/100ps
// contact of one mechanical switch, wired as its type says
module ltm_switch_model
    import ltm_pkg::*;
(
    // wiring type and actuator
    input wire logic [15:0] i_type,
    input wire logic i_hit,
    // level at the drive input
    output logic o_pin
);
    // contact by wiring
    // an ignored input still follows the cam, as a real wire would
    always_comb begin
        o_pin = (i_type == LTM_SW_NO) ? i_hit : !i_hit;
    end
endmodule // ltm_switch_model

// >>> ltm_sync.sv
`timescale 1ns/100ps
// two-stage level synchroniser, one per input bit
module ltm_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // first stage, read only by the second
    logic [WIDTH-1:0] meta_reg;

    // both stages clear to zero under reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule // ltm_sync

// >>> ltm_travel_limit_monitor.sv
`timescale 1ns/100ps
// Functional notes
// - hardware switch trip stops, errors, state 7
// - fault reset clears error, returns state 6
// - after switch trip, only move away
// - positive switch type 0 off,1 NC,2 NO
// - negative switch type same coding, NC default
// - switch types written only disabled, apply at enable
// - reference switch only while homing toward it
// - reference type 1 NC, 2 NO, 0 refused
// - soft limit reached stops, errors, state 7
// - after soft limit stop, only move away
// - soft limits checked only with valid zero
// - target modes check target, stop before limit
// - modes without target quick stop at limit
// - reach behaviour 0 at limit, 1 ahead
// - soft enable 0..3, needs valid zero point
// - signed soft limits, disabled writes, apply at enable
module ltm_travel_limit_monitor
    import ltm_pkg::*;
#(
    parameter int POS_W = 32
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // raw switch inputs
    input wire logic i_positive_travel_switch,
    input wire logic i_negative_travel_switch,
    input wire logic i_reference_switch,
    // drive and motion status
    input wire logic i_power_enable,
    input wire logic i_fault_reset,
    input wire ltm_pkg::ltm_mode_t i_op_mode,
    input wire logic i_homing_to_ref,
    input wire logic i_zero_valid,
    input wire logic i_move_start,
    input wire logic i_move_pos,
    input wire logic i_move_neg,
    // positions in user units
    input wire logic signed [POS_W-1:0] i_actual_pos,
    input wire logic signed [POS_W-1:0] i_target_pos,
    input wire logic [POS_W-1:0] i_stop_distance,
    // parameter port
    input wire logic i_par_wr,
    input wire logic i_par_rd,
    input wire logic [15:0] i_par_addr,
    input wire logic [31:0] i_par_wdata,
    output logic [31:0] o_par_rdata,
    output logic o_par_ack,
    output logic o_par_reject,
    // monitor results
    output ltm_pkg::ltm_state_t o_drive_state,
    output logic o_quick_stop,
    output logic o_limit_error,
    output logic [ltm_pkg::LTM_ERR_W-1:0] o_error_src,
    output logic o_inhibit_pos,
    output logic o_inhibit_neg,
    output logic o_target_beyond,
    output logic o_ref_switch_hit
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // synchronised switch levels: bit 0 pos, 1 neg, 2 ref
    logic [2:0] sw_sync;
    // shadow settings written by software
    logic [15:0] pos_type_reg;
    logic [15:0] neg_type_reg;
    logic [15:0] ref_type_reg;
    logic [15:0] reach_reg;
    logic [15:0] soft_en_reg;
    logic signed [POS_W-1:0] soft_pos_reg;
    logic signed [POS_W-1:0] soft_neg_reg;
    // copies in force since the last power stage enable
    logic [15:0] pos_type_act_reg;
    logic [15:0] neg_type_act_reg;
    logic [15:0] ref_type_act_reg;
    logic signed [POS_W-1:0] soft_pos_act_reg;
    logic signed [POS_W-1:0] soft_neg_act_reg;
    // power enable edge detect
    logic power_dly_reg;
    logic power_rise;
    // evaluated switch levels
    logic pos_hw_active;
    logic neg_hw_active;
    logic ref_active;
    // soft limit evaluation
    logic soft_on;
    logic target_mode;
    logic use_ahead;
    logic signed [POS_W:0] pos_ahead;
    logic signed [POS_W:0] neg_ahead;
    logic pos_sw_hit;
    logic neg_sw_hit;
    // trip events in this cycle
    logic [LTM_ERR_W-1:0] trip_now;
    logic toward_blocked;
    logic new_error;
    // direction inhibits
    logic inhibit_pos_next;
    logic inhibit_neg_next;
    // state
    ltm_state_t state_reg;
    ltm_state_t state_next;
    // parameter write checks
    logic wr_allowed;
    logic wr_valid;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // switch type decode, shared by all three switches
    function automatic logic switch_eval(input logic [15:0] kind, input logic level);
        logic result;
        result = 1'b0;
        if (kind == LTM_SW_NC) begin
            result = ~level;
        end else if (kind == LTM_SW_NO) begin
            result = level;
        end
        return result;
    endfunction

    // legal limit switch type
    function automatic logic limit_type_ok(input logic [31:0] value);
        return value[15:0] <= LTM_SW_NO && value[31:16] == 16'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation

    ltm_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_reference_switch, i_negative_travel_switch, i_positive_travel_switch}),
        .o_sync(sw_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // parameter port

    // switch type and soft limit writes are blocked while the power stage is enabled
    assign wr_allowed = ~i_power_enable;

    // value and permission check per address
    always_comb begin
        wr_valid = 1'b0;
        case (i_par_addr)
            LTM_ADDR_POS_TYPE, LTM_ADDR_NEG_TYPE: begin
                wr_valid = wr_allowed && limit_type_ok(i_par_wdata);
            end
            LTM_ADDR_REF_TYPE: begin
                wr_valid = wr_allowed && i_par_wdata[31:16] == 16'h0000
                    && (i_par_wdata[15:0] == LTM_SW_NC || i_par_wdata[15:0] == LTM_SW_NO);
            end
            LTM_ADDR_REACH: begin
                wr_valid = i_par_wdata[31:16] == 16'h0000 && i_par_wdata[15:0] <= LTM_REACH_AT;
            end
            LTM_ADDR_SOFT_ENABLE: begin
                wr_valid = i_par_wdata[31:16] == 16'h0000 && i_par_wdata[15:0] <= LTM_SOFT_BOTH
                    && (i_zero_valid || i_par_wdata[15:0] == LTM_SOFT_NONE);
            end
            LTM_ADDR_SOFT_POS, LTM_ADDR_SOFT_NEG: begin
                wr_valid = wr_allowed;
            end
            default: begin
                wr_valid = 1'b0;
            end
        endcase
    end

    // shadow settings, stored on an accepted write
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pos_type_reg <= LTM_RST_SWITCH_TYPE;
            neg_type_reg <= LTM_RST_SWITCH_TYPE;
            ref_type_reg <= LTM_RST_SWITCH_TYPE;
            reach_reg <= LTM_RST_REACH;
            soft_en_reg <= LTM_RST_SOFT_ENABLE;
            soft_pos_reg <= LTM_RST_SOFT_POS;
            soft_neg_reg <= LTM_RST_SOFT_NEG;
        end else if (i_par_wr && wr_valid) begin
            case (i_par_addr)
                LTM_ADDR_POS_TYPE: begin
                    pos_type_reg <= i_par_wdata[15:0];
                end
                LTM_ADDR_NEG_TYPE: begin
                    neg_type_reg <= i_par_wdata[15:0];
                end
                LTM_ADDR_REF_TYPE: begin
                    ref_type_reg <= i_par_wdata[15:0];
                end
                LTM_ADDR_REACH: begin
                    reach_reg <= i_par_wdata[15:0];
                end
                LTM_ADDR_SOFT_ENABLE: begin
                    soft_en_reg <= i_par_wdata[15:0];
                end
                LTM_ADDR_SOFT_POS: begin
                    soft_pos_reg <= i_par_wdata;
                end
                LTM_ADDR_SOFT_NEG: begin
                    soft_neg_reg <= i_par_wdata;
                end
                default: begin
                    soft_en_reg <= soft_en_reg;
                end
            endcase
        end
    end

    // read data, ack and reject, one cycle after the request
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_par_rdata <= 32'h0000_0000;
            o_par_ack <= 1'b0;
            o_par_reject <= 1'b0;
        end else begin
            o_par_ack <= i_par_wr || i_par_rd;
            o_par_reject <= i_par_wr && ~wr_valid;
            if (i_par_rd) begin
                // reads return the written value, not the copy in force
                case (i_par_addr)
                    LTM_ADDR_POS_TYPE: o_par_rdata <= {16'h0000, pos_type_reg};
                    LTM_ADDR_NEG_TYPE: o_par_rdata <= {16'h0000, neg_type_reg};
                    LTM_ADDR_REF_TYPE: o_par_rdata <= {16'h0000, ref_type_reg};
                    LTM_ADDR_REACH: o_par_rdata <= {16'h0000, reach_reg};
                    LTM_ADDR_SOFT_ENABLE: o_par_rdata <= {16'h0000, soft_en_reg};
                    LTM_ADDR_SOFT_POS: o_par_rdata <= soft_pos_reg;
                    LTM_ADDR_SOFT_NEG: o_par_rdata <= soft_neg_reg;
                    default: o_par_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings in force

    assign power_rise = i_power_enable && ~power_dly_reg;

    // power enable edge detector
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            power_dly_reg <= 1'b0;
        end else begin
            power_dly_reg <= i_power_enable;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pos_type_act_reg <= LTM_RST_SWITCH_TYPE;
            neg_type_act_reg <= LTM_RST_SWITCH_TYPE;
            ref_type_act_reg <= LTM_RST_SWITCH_TYPE;
            soft_pos_act_reg <= LTM_RST_SOFT_POS;
            soft_neg_act_reg <= LTM_RST_SOFT_NEG;
        end else if (power_rise) begin
            pos_type_act_reg <= pos_type_reg;
            neg_type_act_reg <= neg_type_reg;
            ref_type_act_reg <= ref_type_reg;
            soft_pos_act_reg <= soft_pos_reg;
            soft_neg_act_reg <= soft_neg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch evaluation

    assign pos_hw_active = switch_eval(pos_type_act_reg, sw_sync[0]);
    assign neg_hw_active = switch_eval(neg_type_act_reg, sw_sync[1]);
    assign ref_active = switch_eval(ref_type_act_reg, sw_sync[2]);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_ref_switch_hit <= 1'b0;
        end else begin
            o_ref_switch_hit <= i_op_mode == LTM_MODE_HOMING && i_homing_to_ref && ref_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft limit evaluation

    assign soft_on = i_zero_valid;
    assign target_mode = i_op_mode == LTM_MODE_JOG_STEP || i_op_mode == LTM_MODE_PROFILE_POS;
    // target modes always stop before the limit; others follow the setting
    // ahead-of-limit selection
    assign use_ahead = target_mode || reach_reg == LTM_REACH_AT;

    always_comb begin
        pos_ahead = $signed({i_actual_pos[POS_W-1], i_actual_pos});
        neg_ahead = $signed({i_actual_pos[POS_W-1], i_actual_pos});
        if (use_ahead) begin
            pos_ahead = pos_ahead + $signed({1'b0, i_stop_distance});
            neg_ahead = neg_ahead - $signed({1'b0, i_stop_distance});
        end
    end

    assign pos_sw_hit = soft_on && soft_en_reg[LTM_SOFT_POS_BIT] && i_move_pos
        && pos_ahead >= $signed({soft_pos_act_reg[POS_W-1], soft_pos_act_reg});
    assign neg_sw_hit = soft_on && soft_en_reg[LTM_SOFT_NEG_BIT] && i_move_neg
        && neg_ahead <= $signed({soft_neg_act_reg[POS_W-1], soft_neg_act_reg});

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_target_beyond <= 1'b0;
        end else if (i_move_start && target_mode) begin
            // only a flag: the move still starts normally
            o_target_beyond <= soft_on
                && ((soft_en_reg[LTM_SOFT_POS_BIT] && i_target_pos > soft_pos_act_reg)
                || (soft_en_reg[LTM_SOFT_NEG_BIT] && i_target_pos < soft_neg_act_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trips, inhibits and error

    assign trip_now[LTM_ERR_HW_POS] = pos_hw_active && i_move_pos;
    assign trip_now[LTM_ERR_HW_NEG] = neg_hw_active && i_move_neg;
    assign trip_now[LTM_ERR_SW_POS] = pos_sw_hit;
    assign trip_now[LTM_ERR_SW_NEG] = neg_sw_hit;

    assign toward_blocked = (o_inhibit_pos && i_move_pos) || (o_inhibit_neg && i_move_neg);
    assign new_error = state_reg == LTM_ST_OP_ENABLED && ((|trip_now) || toward_blocked);

    // an inhibit stays until its cause has gone; a new trip wins over release
    always_comb begin
        inhibit_pos_next = o_inhibit_pos;
        inhibit_neg_next = o_inhibit_neg;
        if (~pos_hw_active && ~(soft_on && soft_en_reg[LTM_SOFT_POS_BIT]
            && i_actual_pos >= soft_pos_act_reg)) begin
            inhibit_pos_next = 1'b0;
        end
        if (~neg_hw_active && ~(soft_on && soft_en_reg[LTM_SOFT_NEG_BIT]
            && i_actual_pos <= soft_neg_act_reg)) begin
            inhibit_neg_next = 1'b0;
        end
        if (trip_now[LTM_ERR_HW_POS] || trip_now[LTM_ERR_SW_POS]) begin
            inhibit_pos_next = 1'b1;
        end
        if (trip_now[LTM_ERR_HW_NEG] || trip_now[LTM_ERR_SW_NEG]) begin
            inhibit_neg_next = 1'b1;
        end
    end

    // direction inhibit flags
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_inhibit_pos <= 1'b0;
            o_inhibit_neg <= 1'b0;
        end else begin
            o_inhibit_pos <= inhibit_pos_next;
            o_inhibit_neg <= inhibit_neg_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_limit_error <= 1'b0;
            o_error_src <= '0;
        end else if (new_error) begin
            o_limit_error <= 1'b1;
            o_error_src <= o_error_src | trip_now;
        end else if (i_fault_reset) begin
            o_limit_error <= 1'b0;
            o_error_src <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive state

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LTM_ST_DISABLED: begin
                if (i_power_enable) begin
                    state_next = LTM_ST_OP_ENABLED;
                end
            end
            LTM_ST_OP_ENABLED: begin
                if (~i_power_enable) begin
                    state_next = LTM_ST_DISABLED;
                end else if (new_error) begin
                    state_next = LTM_ST_QUICK_STOP;
                end
            end
            LTM_ST_QUICK_STOP: begin
                if (~i_power_enable) begin
                    state_next = LTM_ST_DISABLED;
                end else if (i_fault_reset) begin
                    state_next = LTM_ST_OP_ENABLED;
                end
            end
            default: begin
                state_next = LTM_ST_DISABLED;
            end
        endcase
    end

    // state register and quick stop request
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= LTM_ST_DISABLED;
            o_quick_stop <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_quick_stop <= state_next == LTM_ST_QUICK_STOP;
        end
    end

    assign o_drive_state = state_reg;

endmodule // ltm_travel_limit_monitor

// >>> ltm_travel_limit_monitor_sva.sv
`timescale 1ns/100ps
// port-level checks of the travel limit monitor
module ltm_travel_limit_monitor_sva
    import ltm_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // watched inputs
    input wire logic i_power_enable,
    input wire logic i_fault_reset,
    input wire ltm_pkg::ltm_mode_t i_op_mode,
    input wire logic i_homing_to_ref,
    input wire logic i_move_pos,
    input wire logic i_move_neg,
    input wire logic i_par_wr,
    input wire logic i_par_rd,
    input wire logic [15:0] i_par_addr,
    // watched outputs
    input wire logic o_par_ack,
    input wire logic o_par_reject,
    input wire ltm_pkg::ltm_state_t o_drive_state,
    input wire logic o_quick_stop,
    input wire logic o_limit_error,
    input wire logic o_ref_switch_hit
);
    // all checks share the one drive clock
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    AST_QS_STATE: assert property (
        o_quick_stop == (o_drive_state == LTM_ST_QUICK_STOP))
        else $error("quick stop flag disagrees with state");
    AST_ERR_AT_STOP: assert property (
        $rose(o_quick_stop) |-> o_limit_error)
        else $error("stop entered without error");
    AST_ACK: assert property (
        (i_par_wr || i_par_rd) |=> o_par_ack)
        else $error("parameter access not acknowledged");
    AST_REJ_POWERED: assert property (
        i_par_wr && i_power_enable && i_par_addr == LTM_ADDR_POS_TYPE |=> o_par_reject)
        else $error("type write accepted while powered");
    AST_FAULT_RST: assert property (
        o_drive_state == LTM_ST_QUICK_STOP && i_fault_reset && i_power_enable && !i_move_pos && !i_move_neg
        |=> o_drive_state == LTM_ST_OP_ENABLED && !o_limit_error)
        else $error("fault reset did not return to enabled");
    AST_ERR_LATCH: assert property (
        o_limit_error && !i_fault_reset |=> o_limit_error)
        else $error("error dropped without fault reset");
    AST_STILL: assert property (
        o_drive_state == LTM_ST_OP_ENABLED && !i_move_pos && !i_move_neg |=> !o_quick_stop)
        else $error("stop without motion toward a limit");
    AST_REF_GATED: assert property (
        !(i_op_mode == LTM_MODE_HOMING && i_homing_to_ref) |=> !o_ref_switch_hit)
        else $error("reference switch seen outside homing");
endmodule // ltm_travel_limit_monitor_sva

bind ltm_travel_limit_monitor ltm_travel_limit_monitor_sva chk_u (.i_sys_clk, .i_rst, .i_power_enable,
    .i_fault_reset, .i_op_mode, .i_homing_to_ref, .i_move_pos, .i_move_neg, .i_par_wr, .i_par_rd,
    .i_par_addr, .o_par_ack, .o_par_reject, .o_drive_state, .o_quick_stop, .o_limit_error, .o_ref_switch_hit);

// >>> test_travel_limit_monitor.sv
`timescale 1ns/100ps
module test_travel_limit_monitor;
    import ltm_pkg::*;
    // one parameter access and its expected answer
    typedef struct packed {
        logic wr;
        logic [15:0] a;
        logic [31:0] d;
        logic pw;
        logic rj;
        logic [31:0] q;
    } ltm_row_t;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_power_enable = 1'b0, i_fault_reset = 1'b0;
    logic i_homing_to_ref = 1'b0, i_zero_valid = 1'b0, i_move_start = 1'b0;
    logic i_move_pos = 1'b0, i_move_neg = 1'b0, i_par_wr = 1'b0, i_par_rd = 1'b0;
    logic [15:0] i_par_addr = '0;
    logic [31:0] i_par_wdata = '0, i_stop_distance = 32'h0000_000a;
    logic signed [31:0] i_actual_pos = '0, i_target_pos = '0;
    ltm_mode_t i_op_mode = LTM_MODE_PROFILE_VEL;
    // switch actuators: positive, negative, reference
    logic [2:0] hit = 3'b000;
    logic [15:0] pos_type = LTM_SW_NC;
    logic i_positive_travel_switch, i_negative_travel_switch, i_reference_switch, o_target_beyond, o_ref_switch_hit;
    logic [31:0] o_par_rdata;
    logic o_par_ack, o_par_reject, o_quick_stop, o_limit_error, o_inhibit_pos, o_inhibit_neg;
    logic [3:0] o_error_src;
    ltm_state_t o_drive_state;
    int num_errors = 0, n_tests = 0, cyc = 0;
    // reads of reset values, then refused and accepted writes
    ltm_row_t rows [14] = '{
        '{1'b0, LTM_ADDR_REF_TYPE, '0, 1'b0, 1'b0, 32'h0000_0001},
        '{1'b0, LTM_ADDR_NEG_TYPE, '0, 1'b0, 1'b0, 32'h0000_0001},
        '{1'b0, LTM_ADDR_POS_TYPE, '0, 1'b0, 1'b0, 32'h0000_0001},
        '{1'b0, LTM_ADDR_REACH, '0, 1'b0, 1'b0, 32'h0000_0000},
        '{1'b0, LTM_ADDR_SOFT_ENABLE, '0, 1'b0, 1'b0, 32'h0000_0000},
        '{1'b0, LTM_ADDR_SOFT_POS, '0, 1'b0, 1'b0, 32'h7fff_ffff},
        '{1'b0, LTM_ADDR_SOFT_NEG, '0, 1'b0, 1'b0, 32'h8000_0000},
        '{1'b1, LTM_ADDR_POS_TYPE, 32'h0000_0003, 1'b0, 1'b1, '0},
        '{1'b1, LTM_ADDR_REF_TYPE, 32'h0000_0000, 1'b0, 1'b1, '0},
        '{1'b1, LTM_ADDR_SOFT_ENABLE, 32'h0000_0003, 1'b0, 1'b1, '0},
        '{1'b1, 16'h0700, 32'h0000_0001, 1'b0, 1'b1, '0},
        '{1'b1, LTM_ADDR_POS_TYPE, 32'h0000_0002, 1'b1, 1'b1, '0},
        '{1'b1, LTM_ADDR_POS_TYPE, 32'h0000_0002, 1'b0, 1'b0, '0},
        '{1'b0, LTM_ADDR_POS_TYPE, '0, 1'b0, 1'b0, 32'h0000_0002}
    };
    ////////////////////////////////////////////////////////////
    // each switch model on its own input
    ltm_switch_model sw_pos_u (.i_type(pos_type), .i_hit(hit[0]), .o_pin(i_positive_travel_switch));
    ltm_switch_model sw_neg_u (.i_type(LTM_SW_NC), .i_hit(hit[1]), .o_pin(i_negative_travel_switch));
    ltm_switch_model sw_ref_u (.i_type(LTM_SW_NC), .i_hit(hit[2]), .o_pin(i_reference_switch));
    ltm_travel_limit_monitor #(.POS_W(32)) dut_u (.i_sys_clk, .i_rst, .i_positive_travel_switch,
        .i_negative_travel_switch, .i_reference_switch, .i_power_enable, .i_fault_reset, .i_op_mode,
        .i_homing_to_ref, .i_zero_valid, .i_move_start, .i_move_pos, .i_move_neg, .i_actual_pos,
        .i_target_pos, .i_stop_distance, .i_par_wr, .i_par_rd, .i_par_addr, .i_par_wdata, .o_par_rdata,
        .o_par_ack, .o_par_reject, .o_drive_state, .o_quick_stop, .o_limit_error, .o_error_src,
        .o_inhibit_pos, .o_inhibit_neg, .o_target_beyond, .o_ref_switch_hit);
    ////////////////////////////////////////////////////////////
    // 8 ns clock
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // hang guard, well above the run length
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("TB: errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // strobe for one edge, answer in the next cycle, then one idle cycle
    task automatic par(input ltm_row_t r);
        i_power_enable = r.pw;
        i_par_wr = r.wr;
        i_par_rd = !r.wr;
        i_par_addr = r.a;
        i_par_wdata = r.d;
        tick(1);
        i_par_wr = 1'b0;
        i_par_rd = 1'b0;
        chk({o_par_ack, o_par_reject}, {1'b1, r.rj});
        if (!r.wr) begin
            chk(o_par_rdata, r.q);
        end
        tick(1);
    endtask
    // bounded wait for the stop, then state and error source
    task automatic wait_stop(input int b);
        int k;
        k = 0;
        while (o_quick_stop !== 1'b1 && k < 12) begin
            tick(1);
            k = k + 1;
        end
        chk({o_drive_state, o_limit_error, o_error_src[b]}, {LTM_ST_QUICK_STOP, 2'b11});
    endtask
    // stop all motion and pulse fault reset
    task automatic clr();
        i_move_pos = 1'b0;
        i_move_neg = 1'b0;
        i_fault_reset = 1'b1;
        tick(1);
        i_fault_reset = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        tick(6);
        i_rst = 1'b0;
        foreach (rows[k]) begin
            par(rows[k]);
        end
        // normally open positive switch, loaded at enable
        pos_type = LTM_SW_NO;
        i_power_enable = 1'b1;
        tick(2);
        chk(o_drive_state, LTM_ST_OP_ENABLED);
        i_move_pos = 1'b1;
        hit[0] = 1'b1;
        wait_stop(LTM_ERR_HW_POS);
        chk({o_inhibit_pos, o_inhibit_neg}, 2'b10);
        clr();
        chk({o_drive_state, o_limit_error}, {LTM_ST_OP_ENABLED, 1'b0});
        i_move_neg = 1'b1;
        tick(3);
        chk(o_drive_state, LTM_ST_OP_ENABLED);
        i_move_neg = 1'b0;
        i_move_pos = 1'b1;
        wait_stop(LTM_ERR_HW_POS);
        // soft positive limit at 100, zero point missing first
        hit[0] = 1'b0;
        i_zero_valid = 1'b1;
        par('{1'b1, LTM_ADDR_SOFT_POS, 32'h0000_0064, 1'b0, 1'b0, '0});
        par('{1'b1, LTM_ADDR_SOFT_ENABLE, 32'h0000_0001, 1'b0, 1'b0, '0});
        clr();
        i_zero_valid = 1'b0;
        i_actual_pos = 32'sh0000_00c8;
        i_power_enable = 1'b1;
        i_move_pos = 1'b1;
        tick(4);
        chk(o_drive_state, LTM_ST_OP_ENABLED);
        i_zero_valid = 1'b1;
        i_actual_pos = -32'sh0000_0005;
        tick(4);
        chk(o_drive_state, LTM_ST_OP_ENABLED);
        i_actual_pos = 32'sh0000_0064;
        wait_stop(LTM_ERR_SW_POS);
        clr();
        chk({o_drive_state, o_inhibit_pos}, {LTM_ST_OP_ENABLED, 1'b1});
        i_actual_pos = '0;
        i_op_mode = LTM_MODE_PROFILE_POS;
        tick(1);
        i_target_pos = 32'sh0000_01f4;
        i_move_start = 1'b1;
        i_move_pos = 1'b1;
        tick(1);
        i_move_start = 1'b0;
        tick(3);
        chk({o_target_beyond, o_drive_state}, {1'b1, LTM_ST_OP_ENABLED});
        i_actual_pos = 32'sh0000_005a;
        wait_stop(LTM_ERR_SW_POS);
        // reference switch only while homing toward it
        clr();
        i_op_mode = LTM_MODE_HOMING;
        i_homing_to_ref = 1'b1;
        hit[2] = 1'b1;
        tick(4);
        chk(o_ref_switch_hit, 1'b1);
        i_homing_to_ref = 1'b0;
        tick(2);
        chk(o_ref_switch_hit, 1'b0);
        final_report();
    end
endmodule // test_travel_limit_monitor
